/* File: rtl/sfwp_guard.sv */
// write-protection guard of a serial flash: frames host commands and lets only legal changes through
// assumes: pins are asynchronous to sys_clk_i and slow (serial clock well below a quarter of it)
//
// Behaviour
// R1 - power-up reset puts receiver in standby
// R2 - commands count only if ending on byte
// R3 - changes need write latch flag set first
// R4 - sleep ignores all but wake/signature/suspend/resume/reset
// R5 - level bits and select make region read-only
// R6 - select 0: top 2^(n-1) blocks protected
// R7 - select 1: bottom 2^(n-1) blocks protected
// R8 - levels 11..15 protect every block
// R9 - security bit 0 shows factory lock
// R10 - secured area programmable only inside secured mode
// R11 - security write sets customer lock bit 1
// R12 - locks never clear, locked area never changes
// R13 - secured mode blocks main array access
// R14 - offsets 000-00F serial, 010-1FF customer
// R15 - hardware reset pin is active low
// R16 - lane zero in, lane one out single
// R17 - lanes two/three only for quad read
// R18 - protect bits held as status bits
// R19 - changes to protected blocks are rejected
// R20 - check whole address before any change
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
module sfwp_guard
  import sfwp_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              hw_reset_n_i,
  input  wire logic              data_lane_zero_i,
  output logic                   data_lane_one_o,
  output logic                   data_lane_one_oe_o,
  output logic                   data_lane_two_o,
  output logic                   data_lane_two_oe_o,
  output logic                   data_lane_three_o,
  output logic                   data_lane_three_oe_o,
  input  wire logic              factory_lock_i,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [31:0]            reg_rdata_o,
  output logic                   op_valid_o,
  output logic                   op_reject_o,
  output logic [2:0]             op_kind_o,
  output logic                   op_otp_o,
  output logic [ADDR_W-1:0]      op_addr_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bits are sclk, cs_n, lane zero, reset_n
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;

  // two flops then one more stage for edge finding
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_q <= 4'hA;
      sync2_q <= 4'hA;
      sync3_q <= 4'hA;
    end else begin
      sync1_q <= {hw_reset_n_i, data_lane_zero_i, cs_n_i, sclk_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  logic lane0;
  logic pin_reset;

  assign sclk_rise = sync2_q[0] & ~sync3_q[0];          // data latched on rising serial clock
  assign cs_fall   = ~sync2_q[1] & sync3_q[1];
  assign cs_rise   = sync2_q[1] & ~sync3_q[1];
  assign lane0     = sync2_q[2];                         // R16
  assign pin_reset = ~sync2_q[3];                        // R15

  ////////////////////////////////////////////////////////////////////////////
  // command decoding helpers
  function automatic logic is_known(input logic [7:0] op);
    is_known = (op == OP_WR_EN) || (op == OP_WRDI) || (op == OP_WRSR) || (op == OP_PP4B) ||
               (op == OP_SE4B) || (op == OP_BE32K4B) || (op == OP_BE4B) || (op == OP_CE) ||
               (op == OP_DP) || (op == OP_WAKE) || (op == OP_ENSO) || (op == OP_EXSO) ||
               (op == OP_SREG_WR) || (op == OP_SUSPEND) || (op == OP_RESUME) ||
               (op == OP_RSTEN) || (op == OP_RST);
  endfunction : is_known

  function automatic logic sleep_ok(input logic [7:0] op);
    sleep_ok = (op == OP_WAKE) || (op == OP_SUSPEND) || (op == OP_RESUME) ||
               (op == OP_RSTEN) || (op == OP_RST);
  endfunction : sleep_ok

  ////////////////////////////////////////////////////////////////////////////
  // frame receiver
  sfwp_state_t       state_q, state_d;
  logic [2:0]        bit_cnt_q, bit_cnt_d;
  logic [2:0]        byte_cnt_q, byte_cnt_d;
  logic [6:0]        shift_q, shift_d;
  logic [7:0]        opcode_q, opcode_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              dpd_q;
  logic [7:0]        new_byte;

  assign new_byte = {shift_q, lane0};

  // shift bits, count whole bytes, drop unknown or sleeping commands
  always_comb begin
    state_d    = state_q;
    bit_cnt_d  = bit_cnt_q;
    byte_cnt_d = byte_cnt_q;
    shift_d    = shift_q;
    opcode_d   = opcode_q;
    addr_d     = addr_q;
    unique case (state_q)
      ST_STANDBY: begin
        if (cs_fall) begin
          state_d    = ST_SHIFT;
          bit_cnt_d  = 3'h0;
          byte_cnt_d = 3'h0;
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          state_d = ST_STANDBY;
        end else if (sclk_rise) begin
          bit_cnt_d = bit_cnt_q + 3'h1;
          shift_d   = new_byte[6:0];
          if (bit_cnt_q == 3'h7) begin
            if (byte_cnt_q != 3'h7) begin
              byte_cnt_d = byte_cnt_q + 3'h1;
            end
            if (byte_cnt_q == 3'h0) begin
              opcode_d = new_byte;
              if (!is_known(new_byte) || (dpd_q && !sleep_ok(new_byte))) begin
                state_d = ST_DROP;                       // R4
              end
            end else if (byte_cnt_q <= LEN_ADDR) begin
              addr_d = {addr_q[ADDR_W-9:0], new_byte};
            end
          end
        end
      end
      ST_DROP: begin
        if (cs_rise) begin
          state_d = ST_STANDBY;
        end
      end
      default: begin
        state_d = ST_STANDBY;
      end
    endcase
    if (pin_reset) begin
      state_d = ST_STANDBY;                              // R15
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q    <= ST_STANDBY;                          // R1
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 3'h0;
      shift_q    <= 7'h00;
      opcode_q   <= 8'h00;
      addr_q     <= '0;
    end else begin
      state_q    <= state_d;
      bit_cnt_q  <= bit_cnt_d;
      byte_cnt_q <= byte_cnt_d;
      shift_q    <= shift_d;
      opcode_q   <= opcode_d;
      addr_q     <= addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection state and command execution
  logic        wlf_q, wlf_d;
  logic        dpd_d;
  logic        sec_q, sec_d;
  logic        susp_q, susp_d;
  logic        rsten_q, rsten_d;
  logic [3:0]  level_q, level_d;
  logic        tb_q, tb_d;
  logic        cust_q, cust_d;
  logic        fact_q;
  logic        valid_q, valid_d;
  logic        reject_q, reject_d;
  sfwp_kind_t  kind_q, kind_d;
  logic        otp_q, otp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        exec;
  logic        is_mod;
  logic        blk_hit;
  logic        any_prot;
  logic        bad;

  // executes only when the frame ends on a byte boundary
  assign exec = (state_q == ST_SHIFT) && cs_rise && (bit_cnt_q == 3'h0) && (byte_cnt_q != 3'h0); // R2

  sfwp_region #(
    .BW        (BLK_W)
  ) u_region (
    .level_i   (level_q),
    .top_bot_i (tb_q),
    .block_i   (addr_q[BLK_LSB+BLK_W-1:BLK_LSB]),
    .hit_o     (blk_hit),
    .any_o     (any_prot)
  );

  always_comb begin
    wlf_d    = wlf_q;
    dpd_d    = dpd_q;
    sec_d    = sec_q;
    susp_d   = susp_q;
    rsten_d  = rsten_q;
    level_d  = level_q;
    tb_d     = tb_q;
    cust_d   = cust_q;
    valid_d  = 1'b0;
    reject_d = 1'b0;
    kind_d   = kind_q;
    otp_d    = otp_q;
    is_mod   = 1'b0;
    bad      = 1'b0;
    rdata_d  = 32'h0000_0000;
    // software access to the protect bits; a command in the same cycle wins
    if (reg_wr_i && (reg_addr_i == REG_PROT)) begin
      level_d = reg_wdata_i[3:0];                        // R18
      tb_d    = reg_wdata_i[PROT_TB_BIT];
    end
    if (exec && !(dpd_q && !sleep_ok(opcode_q))) begin  // R4
      rsten_d = 1'b0;
      unique case (opcode_q)
        OP_WR_EN:   if (byte_cnt_q == LEN_CMD) wlf_d = 1'b1;
        OP_WRDI:    if (byte_cnt_q == LEN_CMD) wlf_d = 1'b0;
        OP_DP:      if (byte_cnt_q == LEN_CMD) dpd_d = 1'b1;
        OP_WAKE:    dpd_d = 1'b0;
        OP_ENSO:    if (byte_cnt_q == LEN_CMD) sec_d = 1'b1;  // R10
        OP_EXSO:    if (byte_cnt_q == LEN_CMD) sec_d = 1'b0;  // R10
        OP_SUSPEND: if (byte_cnt_q == LEN_CMD) susp_d = 1'b1;
        OP_RESUME:  if (byte_cnt_q == LEN_CMD) susp_d = 1'b0;
        OP_RSTEN:   if (byte_cnt_q == LEN_CMD) rsten_d = 1'b1;
        OP_RST: begin
          if ((byte_cnt_q == LEN_CMD) && rsten_q) begin
            wlf_d  = 1'b0;
            sec_d  = 1'b0;
            susp_d = 1'b0;
            dpd_d  = 1'b0;
          end
        end
        OP_WRSR: begin
          if ((byte_cnt_q == LEN_WRSR) && wlf_q) begin   // R3
            level_d = addr_q[SR_LVL_LSB+3:SR_LVL_LSB];   // R18
            tb_d    = addr_q[SR_TB_BIT];
            wlf_d   = 1'b0;
          end
        end
        OP_SREG_WR: begin
          if ((byte_cnt_q == LEN_CMD) && wlf_q) begin    // R3
            cust_d = 1'b1;                               // R11
            wlf_d  = 1'b0;
          end
        end
        OP_PP4B: begin
          is_mod = (byte_cnt_q >= LEN_PROG);
          kind_d = KIND_PROG;
        end
        OP_SE4B, OP_BE32K4B, OP_BE4B: begin
          is_mod = (byte_cnt_q == LEN_ERASE);
          kind_d = (opcode_q == OP_SE4B) ? KIND_SECT : ((opcode_q == OP_BE4B) ? KIND_BLK64 : KIND_BLK32);
        end
        OP_CE: begin
          is_mod = (byte_cnt_q == LEN_CMD);
          kind_d = KIND_CHIP;
        end
        default: ;
      endcase
      // whole address and all locks checked before the array is told anything
      if (is_mod) begin                                  // R20
        if (sec_q) begin
          bad = (kind_d != KIND_PROG);                   // R13
          if (addr_q[OTP_MSB:OTP_SN_LSB] == '0) begin
            bad = bad || fact_q;                         // R12 R14
          end else begin
            bad = bad || cust_q;                         // R12 R14
          end
        end else if (kind_d == KIND_CHIP) begin
          bad = any_prot;                                // R5 R19
        end else begin
          bad = blk_hit;                                 // R5 R19
        end
        otp_d    = sec_q;
        valid_d  = wlf_q && !bad;                        // R3
        reject_d = !wlf_q || bad;                        // R19
        wlf_d    = 1'b0;
      end
    end
    if (pin_reset) begin
      wlf_d   = 1'b0;                                    // R15
      dpd_d   = 1'b0;
      sec_d   = 1'b0;
      susp_d  = 1'b0;
      rsten_d = 1'b0;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_STATUS: rdata_d = {28'h0, susp_q, sec_q, dpd_q, wlf_q};
        REG_PROT:   rdata_d = {27'h0, tb_q, level_q};
        REG_SECURE: rdata_d = {30'h0, cust_q, fact_q};   // R9
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wlf_q    <= 1'b0;
      dpd_q    <= 1'b0;
      sec_q    <= 1'b0;
      susp_q   <= 1'b0;
      rsten_q  <= 1'b0;
      level_q  <= LVL_NONE;
      tb_q     <= 1'b0;
      cust_q   <= 1'b0;
      fact_q   <= 1'b0;
      valid_q  <= 1'b0;
      reject_q <= 1'b0;
      kind_q   <= KIND_PROG;
      otp_q    <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else begin
      wlf_q    <= wlf_d;
      dpd_q    <= dpd_d;
      sec_q    <= sec_d;
      susp_q   <= susp_d;
      rsten_q  <= rsten_d;
      level_q  <= level_d;
      tb_q     <= tb_d;
      cust_q   <= cust_d;
      fact_q   <= factory_lock_i;                        // R9
      valid_q  <= valid_d;
      reject_q <= reject_d;
      kind_q   <= kind_d;
      otp_q    <= otp_d;
      rdata_q  <= rdata_d;
    end
  end

  // outputs; lanes one to three are never driven since no read path lives here
  assign reg_rdata_o          = rdata_q;
  assign op_valid_o           = valid_q;
  assign op_reject_o          = reject_q;
  assign op_kind_o            = kind_q;
  assign op_otp_o             = otp_q;
  assign op_addr_o            = addr_q;
  assign data_lane_one_o      = 1'b0;
  assign data_lane_one_oe_o   = 1'b0;                    // R16
  assign data_lane_two_o      = 1'b0;
  assign data_lane_two_oe_o   = 1'b0;                    // R17
  assign data_lane_three_o    = 1'b0;
  assign data_lane_three_oe_o = 1'b0;                    // R17

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_reset_standby;
    @(posedge sys_clk_i) rst_i |=> (state_q == ST_STANDBY) && !wlf_q && !valid_q;
  endproperty
  a_reset_standby: assert property (p_reset_standby) else $error("not in standby after reset"); // R1

  property p_partial_byte;
    @(posedge sys_clk_i) disable iff (rst_i)
      ((state_q == ST_SHIFT) && cs_rise && (bit_cnt_q != 3'h0)) |=> !valid_q && !reject_q;
  endproperty
  a_partial_byte: assert property (p_partial_byte) else $error("partial byte command acted"); // R2

  property p_needs_wlf;
    @(posedge sys_clk_i) disable iff (rst_i) valid_q |-> $past(wlf_q) && !wlf_q;
  endproperty
  a_needs_wlf: assert property (p_needs_wlf) else $error("change without write latch flag"); // R3

  // a forbidden opcode seen in sleep drops the whole frame
  property p_sleep_ignore;
    @(posedge sys_clk_i) disable iff (rst_i)
      (dpd_q && !pin_reset && sclk_rise && (state_q == ST_SHIFT) && (bit_cnt_q == 3'h7) && (byte_cnt_q == 3'h0) &&
       !sleep_ok(new_byte)) |=> (state_q == ST_DROP) && $stable(wlf_q) && $stable(sec_q) && !valid_q;
  endproperty
  a_sleep_ignore: assert property (p_sleep_ignore) else $error("command acted in sleep"); // R4

  property p_block_reject;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec && (opcode_q == OP_SE4B) && (byte_cnt_q == LEN_ERASE) && blk_hit && !sec_q && !dpd_q)
        |=> reject_q && !valid_q;
  endproperty
  a_block_reject: assert property (p_block_reject) else $error("protected block erased"); // R19

  property p_secure_only_prog;
    @(posedge sys_clk_i) disable iff (rst_i) (valid_q && otp_q) |-> (kind_q == KIND_PROG);
  endproperty
  a_secure_only_prog: assert property (p_secure_only_prog) else $error("array touched in secured mode"); // R13

  property p_factory_area;
    @(posedge sys_clk_i) disable iff (rst_i)
      (valid_q && otp_q) |-> !(fact_q && (addr_q[OTP_MSB:OTP_SN_LSB] == '0));
  endproperty
  a_factory_area: assert property (p_factory_area) else $error("factory serial area changed"); // R12

  property p_cust_sticky;
    @(posedge sys_clk_i) disable iff (rst_i) cust_q |=> cust_q;
  endproperty
  a_cust_sticky: assert property (p_cust_sticky) else $error("customer lock cleared"); // R12

  property p_pin_reset;
    @(posedge sys_clk_i) disable iff (rst_i)
      pin_reset |=> (state_q == ST_STANDBY) && !wlf_q && !dpd_q && !sec_q;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin had no effect"); // R15

  property p_lanes_quiet;
    @(posedge sys_clk_i) disable iff (rst_i)
      !data_lane_one_oe_o && !data_lane_two_oe_o && !data_lane_three_oe_o;
  endproperty
  a_lanes_quiet: assert property (p_lanes_quiet) else $error("lane driven without read"); // R16

  property p_all_levels;
    @(posedge sys_clk_i) disable iff (rst_i) (level_q >= LVL_ALL) |-> blk_hit && any_prot;
  endproperty
  a_all_levels: assert property (p_all_levels) else $error("high level left a block open"); // R8

  c_prog_ok: cover property (@(posedge sys_clk_i) disable iff (rst_i) valid_q && !otp_q);
  c_reject:  cover property (@(posedge sys_clk_i) disable iff (rst_i) reject_q);
  c_otp:     cover property (@(posedge sys_clk_i) disable iff (rst_i) valid_q && otp_q);
  c_lock:    cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(cust_q));

endmodule : sfwp_guard

/* File: rtl/sfwp_pkg.sv */
// package of the flash write-protection block: opcodes, register map, field layout, state codes
// assumes: used by sfwp_guard and sfwp_region; 8-bit command opcodes, 32-bit array address
package sfwp_pkg;

  // array geometry
  localparam int          ADDR_W      = 32;
  localparam int          BLK_W       = 10;              // 1024 blocks of 64K
  localparam int          BLK_LSB     = 16;              // block index position in the address
  localparam logic [3:0]  LVL_NONE    = 4'h0;
  localparam logic [3:0]  LVL_ALL     = 4'hB;            // levels 11..15 protect everything

  // secured area: 512 bytes, first 16 bytes hold the factory serial number
  localparam int          OTP_MSB     = 8;               // offset bits [8:0]
  localparam int          OTP_SN_LSB  = 4;               // offsets below 0x010 have [8:4] == 0

  // command opcodes (defaults, one byte each)
  localparam logic [7:0]  OP_WR_EN    = 8'h06;
  localparam logic [7:0]  OP_WRDI     = 8'h04;
  localparam logic [7:0]  OP_WRSR     = 8'h01;
  localparam logic [7:0]  OP_PP4B     = 8'h12;
  localparam logic [7:0]  OP_SE4B     = 8'h21;
  localparam logic [7:0]  OP_BE32K4B  = 8'h5C;
  localparam logic [7:0]  OP_BE4B     = 8'hDC;
  localparam logic [7:0]  OP_CE       = 8'hC7;
  localparam logic [7:0]  OP_DP       = 8'hB9;
  localparam logic [7:0]  OP_WAKE     = 8'hAB;           // wake from sleep and signature read
  localparam logic [7:0]  OP_ENSO     = 8'hB1;
  localparam logic [7:0]  OP_EXSO     = 8'hC1;
  localparam logic [7:0]  OP_SREG_WR  = 8'h2F;
  localparam logic [7:0]  OP_SUSPEND  = 8'hB0;
  localparam logic [7:0]  OP_RESUME   = 8'h30;
  localparam logic [7:0]  OP_RSTEN    = 8'h66;
  localparam logic [7:0]  OP_RST      = 8'h99;

  // frame lengths in bytes
  localparam logic [2:0]  LEN_CMD     = 3'h1;
  localparam logic [2:0]  LEN_WRSR    = 3'h2;
  localparam logic [2:0]  LEN_ERASE   = 3'h5;
  localparam logic [2:0]  LEN_PROG    = 3'h6;            // least: opcode, 4 address, 1 data
  localparam logic [2:0]  LEN_ADDR    = 3'h4;

  // status byte written by the status-write command
  localparam int          SR_LVL_LSB  = 2;               // level in [5:2]
  localparam int          SR_TB_BIT   = 6;

  // register port map (byte addresses)
  localparam logic [3:0]  REG_STATUS  = 4'h0;            // ro: latch flag, sleep, secured, suspended
  localparam logic [3:0]  REG_PROT    = 4'h4;            // rw: level [3:0], top/bottom [4]
  localparam logic [3:0]  REG_SECURE  = 4'h8;            // ro: factory lock [0], customer lock [1]
  localparam int          PROT_TB_BIT = 4;

  // operation kinds handed to the array
  typedef enum logic [2:0] {
    KIND_PROG  = 3'b000,
    KIND_SECT  = 3'b001,
    KIND_BLK32 = 3'b010,
    KIND_BLK64 = 3'b011,
    KIND_CHIP  = 3'b100
  } sfwp_kind_t;

  // frame receiver states
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_SHIFT   = 2'b01,
    ST_DROP    = 2'b10
  } sfwp_state_t;

endpackage : sfwp_pkg

/* File: rtl/sfwp_region.sv */
// protected-region decoder: level bits and top/bottom select against a block index
// assumes: inputs from registers on the same clock; purely combinational
`timescale 1ns/1ps
module sfwp_region
  import sfwp_pkg::*;
#(
  parameter int BW = BLK_W
) (
  input  wire logic [3:0]    level_i,
  input  wire logic          top_bot_i,
  input  wire logic [BW-1:0] block_i,
  output logic               hit_o,
  output logic               any_o
);

  logic [BW:0] span;

  // size of the region is 2^(level-1) blocks for levels 1..10; level 0 protects none, levels 11..15 all
  always_comb begin
    span  = '0;
    hit_o = 1'b0;
    any_o = (level_i != LVL_NONE);
    if (level_i >= LVL_ALL) begin
      hit_o = 1'b1;                                      // R8
    end else if (level_i != LVL_NONE) begin
      span = (BW+1)'(1) << (level_i - 4'h1);
      if (top_bot_i) begin
        hit_o = ({1'b0, block_i} < span);                // R7
      end else begin
        hit_o = ({1'b0, block_i} >= ((BW+1)'(1 << BW) - span)); // R6
      end
    end
  end

endmodule : sfwp_region

/* File: test/sfwp_host.sv */
// partner model: serial host that frames commands on the pins of the guard
// assumes: sys_clk_i is the bench clock at 125 MHz; link clock of 160 ns made from it
`timescale 1ns/1ps
module sfwp_host (
  input  wire logic sys_clk_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      data_lane_zero_o,
  output logic      hw_reset_n_o
);
  // idle: link clock parked low, chip deselected, reset pin released
  initial begin
    sclk_o           = 1'b0;
    cs_n_o           = 1'b1;
    data_lane_zero_o = 1'b0;
    hw_reset_n_o     = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : wait_clk

  // shifts nbits msb first on lane zero, 10 sys clocks per half period
  task automatic frame(input logic [63:0] d, input int nbits);
    @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      data_lane_zero_o <= d[63-i];
      wait_clk(10);
      sclk_o <= 1'b1;
      wait_clk(10);
      sclk_o <= 1'b0;
    end
    wait_clk(10);
    cs_n_o           <= 1'b1;
    data_lane_zero_o <= ~data_lane_zero_o; // released line must not keep last value
  endtask : frame

  // hardware reset request, pin pulled low
  task automatic hw_reset();
    @(posedge sys_clk_i);
    hw_reset_n_o <= 1'b0;
    wait_clk(6);
    hw_reset_n_o <= 1'b1;
    wait_clk(6);
  endtask : hw_reset
endmodule : sfwp_host

/* File: test/sfwp_guard_test.sv */
// self-checking bench of the write-protection guard
// assumes: sfwp_host drives the serial pins; bench drives register port and fuse
`timescale 1ns/1ps
module sfwp_guard_test import sfwp_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [3:0]  addr    = 4'h0;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        flock   = 1'b0;
  wire         sclk, cs_n, lane0, hw_n;
  logic [31:0] rdata, op_addr;
  logic        v_o, r_o, otp, l1, l1e, l2, l2e, l3, l3e;
  logic [2:0]  kind;
  int          failures   = 0;
  int          n_compared = 0;
  logic [31:0] s          = 32'h840c7555;

  ////////////////////////////////////////////////////////////////////////
  always #4 sys_clk = ~sys_clk;

  sfwp_host u_host (.sys_clk_i(sys_clk), .sclk_o(sclk), .cs_n_o(cs_n), .data_lane_zero_o(lane0), .hw_reset_n_o(hw_n));
  sfwp_guard u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .hw_reset_n_i(hw_n),
    .data_lane_zero_i(lane0), .data_lane_one_o(l1), .data_lane_one_oe_o(l1e), .data_lane_two_o(l2),
    .data_lane_two_oe_o(l2e), .data_lane_three_o(l3), .data_lane_three_oe_o(l3e), .factory_lock_i(flock),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .op_valid_o(v_o), .op_reject_o(r_o), .op_kind_o(kind), .op_otp_o(otp), .op_addr_o(op_addr));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // expected protection of one 64K block
  function automatic logic prot(input int l, input int t, input int b);
    if (l == 0) return 1'b0;
    if (l >= 11) return 1'b1;
    return t ? (b < (1 << (l - 1))) : (b >= 1024 - (1 << (l - 1)));
  endfunction : prot

  function automatic logic [63:0] fr(input logic [7:0] op, input logic [31:0] a);
    return {op, a, 24'h5A0000};
  endfunction : fr

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (exp !== got) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask : reg_write

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    @(negedge sys_clk);
    chk("reg_rdata", exp, rdata);
  endtask : rd_chk

  // one frame, then watch the result pulses; x skips a check
  task automatic exec(input logic [63:0] d, input int nb, input logic ev, input logic er);
    logic v;
    logic r;
    v = 1'b0;
    r = 1'b0;
    u_host.frame(d, nb);
    repeat (10) begin
      @(negedge sys_clk);
      if (v_o === 1'b1) v = 1'b1;
      if (r_o === 1'b1) r = 1'b1;
    end
    if (ev !== 1'bx) chk("op_valid", ev, v);
    if (er !== 1'bx) chk("op_reject", er, r);
  endtask : exec

  task automatic cmd(input logic [7:0] op);
    exec({op, 56'h0}, 8, 1'bx, 1'bx);
  endtask : cmd

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////
  // watchdog: longer than the whole sequence
  initial begin
    #780000;
    failures++;
    end_of_test();
  end

  // main sequence
  initial begin
    logic [2:0] kinds [5];
    logic [7:0] ops [5];
    int         n, e, b, lv, tb;
    ops   = '{OP_PP4B, OP_SE4B, OP_BE32K4B, OP_BE4B, OP_CE};
    kinds = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_PROT, 32'h0);
    rd_chk(4'hC, 32'h0);
    chk("lanes", 32'h0, {l1e, l2e, l3e, l1, l2, l3});
    exec({OP_WR_EN, 56'h0}, 7, 1'b0, 1'b0);
    exec({OP_WR_EN, 56'h0}, 9, 1'b0, 1'b0);
    rd_chk(REG_STATUS, 32'h0);
    exec(fr(OP_SE4B, 32'h0012_3456), 40, 1'b0, 1'b1);
    $display("test length and latch finished");
    for (int i = 0; i < 5; i++) begin
      cmd(OP_WR_EN);
      if (i == 0) rd_chk(REG_STATUS, 32'h1);
      exec(fr(ops[i], 32'h0012_3456), i == 0 ? 48 : (i == 4 ? 8 : 40), 1'b1, 1'b0);
      chk("op_kind", kinds[i], kind);
      if (i == 1) chk("op_addr", 32'h0012_3456, op_addr);
    end
    $display("test kinds finished");
    for (int l = 0; l < 16; l++) begin
      for (int t = 0; t < 2; t++) begin
        n = (l == 0) ? 0 : (1 << ((l > 10 ? 10 : l) - 1));
        e = t ? n : 1024 - n;
        reg_write(REG_PROT, {27'h0, t[0], l[3:0]});
        for (int k = 0; k < 2; k++) begin
          b = (e - k) & 1023;
          s = lfsr(s);
          cmd(OP_WR_EN);
          exec(fr(OP_SE4B, {6'h0, b[9:0], s[15:0]}), 40, !prot(l, t, b), prot(l, t, b));
        end
      end
    end
    for (int k = 0; k < 6; k++) begin
      s  = lfsr(s);
      lv = s[3:0];
      tb = s[4];
      b  = s[25:16];
      reg_write(REG_PROT, {27'h0, s[4:0]});
      cmd(OP_WR_EN);
      exec(fr(OP_PP4B, {6'h0, s[25:0]}), 48, !prot(lv, tb, b), prot(lv, tb, b));
      cmd(OP_WR_EN);
      exec({OP_CE, 56'h0}, 8, lv == 0, lv != 0);
    end
    $display("test protection finished");
    cmd(OP_DP);
    rd_chk(REG_STATUS, 32'h2);
    cmd(OP_WR_EN);
    rd_chk(REG_STATUS, 32'h2);
    cmd(OP_SUSPEND);
    rd_chk(REG_STATUS, 32'hA);
    cmd(OP_RESUME);
    cmd(OP_RSTEN);
    cmd(OP_RST);
    rd_chk(REG_STATUS, 32'h0);
    cmd(OP_DP);
    cmd(OP_WAKE);
    rd_chk(REG_STATUS, 32'h0);
    $display("test sleep finished");
    reg_write(REG_PROT, 32'h0);
    cmd(OP_ENSO);
    rd_chk(REG_STATUS, 32'h4);
    cmd(OP_WR_EN);
    exec(fr(OP_SE4B, 32'h0), 40, 1'b0, 1'b1);
    cmd(OP_WR_EN);
    exec(fr(OP_PP4B, 32'h10), 48, 1'b1, 1'b0);
    chk("op_otp", 32'h1, otp);
    cmd(OP_WR_EN);
    cmd(OP_SREG_WR);
    rd_chk(REG_SECURE, 32'h2);
    cmd(OP_WR_EN);
    exec(fr(OP_PP4B, 32'h20), 48, 1'b0, 1'b1);
    @(posedge sys_clk);
    flock <= 1'b1;
    rd_chk(REG_SECURE, 32'h3);
    cmd(OP_WR_EN);
    exec(fr(OP_PP4B, 32'h0), 48, 1'b0, 1'b1);
    cmd(OP_EXSO);
    rd_chk(REG_STATUS, 32'h0);
    $display("test secured area finished");
    reg_write(REG_PROT, 32'h13);
    cmd(OP_WR_EN);
    u_host.hw_reset();
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_PROT, 32'h13);
    $display("test reset pin finished");
    end_of_test();
  end
endmodule : sfwp_guard_test
